// file: rtl/fes_pkg.sv
/*
 * shared constants for the frame repair controller: frame geometry,
 * syndrome decode bases and controller states.
 * assumes a 32-bit word stream on the configuration access port.
 */
package fes_pkg;

    // *****************************************************************
    // frame geometry
    // *****************************************************************
    localparam int         FRAME_BITS  = 1312;         // bits in one frame
    localparam int         WORD_BITS   = 32;           // port data width
    localparam int         FADDR_W     = 24;           // frame address width
    localparam logic [5:0] FRAME_WORDS = 6'h29;        // 41 words per frame
    localparam logic [5:0] LAST_WORD   = 6'h28;        // index of word 40

    // *****************************************************************
    // syndrome layout and decode bases
    // *****************************************************************
    localparam int          SYN_W       = 12;          // syndrome width
    localparam int          SYN_SEC     = 11;          // single-error bit
    localparam logic [10:0] SPLIT       = 11'h400;     // 1024
    localparam logic [10:0] BASE_LO     = 11'h2C0;     // 704, first bit
    localparam logic [10:0] BASE_HI     = 11'h2E0;     // 736
    localparam logic [5:0]  SHORT_BASE  = 6'h16;       // 22 in 32-bit rows
    localparam logic [10:0] PAR_BASE    = 11'h280;     // 640, first parity
    localparam logic [10:0] PAR_OVERALL = 11'h28B;     // 651, overall parity

    // *****************************************************************
    // controller states
    // *****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,   // waiting for start
        ST_READ  = 4'h1,   // reading one frame into the store
        ST_CHECK = 4'h2,   // waiting for the checker strobe
        ST_FETCH = 4'h3,   // reading the word holding the bad bit
        ST_FLIP  = 4'h4,   // writing the word back with the bit inverted
        ST_GOLD  = 4'h5,   // refetching the original frame
        ST_WRITE = 4'h6,   // writing the repaired frame back
        ST_NEXT  = 4'h7    // stepping to the following frame
    } fes_state_e;

endpackage : fes_pkg

// file: rtl/fes_frame_ram.sv
/*
 * one-frame store: 41 words of 32 bits, one write and one read port.
 * assumes a single clock; read data appears one edge after the address.
 */
`timescale 1ns/1ps
module fes_frame_ram (
    // clock
    input  wire logic        i_clk,
    // write side
    input  wire logic        i_we,
    input  wire logic [5:0]  i_waddr,
    input  wire logic [31:0] i_wdata,
    // read side
    input  wire logic [5:0]  i_raddr,
    output logic      [31:0] o_rdata
);

    // storage sized for exactly one frame
    logic [31:0] mem [0:40];

    // *****************************************************************
    // synchronous write and read
    // *****************************************************************
    // no reset: contents are always rewritten before being read
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end

endmodule : fes_frame_ram

// file: rtl/fes_syndrome_decode.sv
/*
 * combinational syndrome decode: classifies the saved syndrome and
 * turns it into the frame index of the bit to invert.
 * assumes the syndrome is stable while the result is used.
 */
`timescale 1ns/1ps
module fes_syndrome_decode (
    // saved syndrome
    input  wire logic [11:0] i_syndrome,
    // classification
    output logic             o_single,
    output logic             o_parity,
    // location of the bit to invert
    output logic      [10:0] o_bit_index
);

    // *****************************************************************
    // classification
    // *****************************************************************
    wire [10:0] s_lo     = i_syndrome[10:0];          // hamming part
    wire [10:0] s_lo_m1  = s_lo - 11'h001;            // for power test
    wire        pow2     = ((s_lo & s_lo_m1) == 11'h000); // zero or 2^k
    wire [10:0] data_idx;                              // data bit index
    wire [10:0] par_idx;                               // parity location

    assign o_single = i_syndrome[fes_pkg::SYN_SEC];
    assign o_parity = o_single & pow2;

    // *****************************************************************
    // data bit: remove the 704 or 736 offset of the address space
    // *****************************************************************
    assign data_idx = (s_lo < fes_pkg::SPLIT) ? (s_lo - fes_pkg::BASE_LO)
                                              : (s_lo - fes_pkg::BASE_HI);

    // *****************************************************************
    // parity bit: position of the lone one, or the overall parity bit
    // *****************************************************************
    logic [3:0] acc [0:11];                            // running bit position
    assign acc[0] = 4'h0;
    genvar k;
    generate
        for (k = 0; k < 11; k++) begin : g_pos
            assign acc[k+1] = acc[k] | (s_lo[k] ? 4'(k) : 4'h0);
        end
    endgenerate
    assign par_idx = (s_lo == 11'h000) ? fes_pkg::PAR_OVERALL
                                       : (fes_pkg::PAR_BASE + {7'h00, acc[11]});

    assign o_bit_index = o_parity ? par_idx : data_idx;

endmodule : fes_syndrome_decode

// file: rtl/fes_repair_ctrl.sv
/*
 * frame repair controller: reads configuration frames one by one into a
 * local store, waits for the frame checker verdict, repairs a single
 * flipped bit in place or reloads an original frame on a double error,
 * writes the frame back to the same address and resumes at the next.
 * assumes the checker strobe follows each frame read, the access port
 * answers reads with busy low, and an original-frame source exists.
 */
// Functional notes
// - sample flag and syndrome only at strobe
// - data error addresses space 704 to 2047
// - subtract 704 below 1024, else 736
// - equivalent: subtract 22 or 23 per row
// - zero or power of two: parity bit
// - bit k maps to 640 plus k
// - hold one whole 1312-bit frame locally
// - read via config port, store, track address
// - halt, save; reload frame or flip bit
// - write back same address, resume next
// - keep state capture off while checking
`timescale 1ns/1ps
module fes_repair_ctrl (
    // clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESET,
    // user control
    input  wire logic        I_START,
    input  wire logic        I_STOP,
    input  wire logic [23:0] I_LAST_FRAME_ADDR,
    // frame checker results
    input  wire logic        I_FRAME_CHECK_VALID,
    input  wire logic        I_FRAME_ERROR_FLAG,
    input  wire logic [11:0] I_SYNDROME,
    // internal configuration access port
    output logic             O_CFG_CE_N,
    output logic             O_CFG_RDWR,
    output logic      [31:0] O_CFG_WDATA,
    input  wire logic [31:0] I_CFG_RDATA,
    input  wire logic        I_CFG_BUSY,
    output logic      [23:0] O_FRAME_ADDR,
    // original frame source
    output logic             O_GOLD_REQ,
    input  wire logic        I_GOLD_VALID,
    input  wire logic [31:0] I_GOLD_DATA,
    // status
    output logic             O_CAPTURE_INHIBIT,
    output logic      [11:0] O_SYNDROME,
    output logic             O_REPAIR_DONE,
    output logic             O_DOUBLE_ERR
);

    // *****************************************************************
    // declarations
    // *****************************************************************
    fes_pkg::fes_state_e state;         // current controller state
    fes_pkg::fes_state_e next_state;    // state for the next edge
    logic [5:0]          cnt;           // word counter within a frame
    logic [5:0]          next_cnt;      // next word count
    logic                wr_pipe;       // store read under way for write
    logic                stop_req;      // sticky stop request
    logic [11:0]         syn;           // syndrome saved at the strobe
    logic [31:0]         ram_rdata;     // store read data
    logic                dec_single;    // saved syndrome: bit 11 set
    logic                dec_parity;    // saved syndrome: parity bit
    logic [10:0]         dec_index;     // frame index of the bad bit

    // *****************************************************************
    // decode and selection
    // *****************************************************************
    // a read word is taken only while the port is selected and not busy
    wire rd_take   = (state == fes_pkg::ST_READ) & ~O_CFG_CE_N
                   & O_CFG_RDWR & ~I_CFG_BUSY;
    wire gold_take = (state == fes_pkg::ST_GOLD) & I_GOLD_VALID;
    wire wr_issue  = (state == fes_pkg::ST_WRITE) & (cnt < fes_pkg::FRAME_WORDS);
    wire cnt_step  = rd_take | gold_take | wr_issue;
    wire take_syn  = (state == fes_pkg::ST_CHECK) & I_FRAME_CHECK_VALID;
    wire is_flip   = (state == fes_pkg::ST_FLIP);
    wire last_addr = (O_FRAME_ADDR == I_LAST_FRAME_ADDR);

    // bad bit sits in word index[10:5], bit index[4:0]
    wire [5:0]  flip_word = dec_index[10:5];
    wire [31:0] flip_mask = 32'h0000_0001 << dec_index[4:0];

    // store ports: one write source per state, so no arbitration needed
    wire        ram_we    = rd_take | gold_take | is_flip;
    wire [5:0]  ram_waddr = is_flip ? flip_word : cnt;
    wire [31:0] ram_wdata = is_flip ? (ram_rdata ^ flip_mask)
                          : ((state == fes_pkg::ST_READ) ? I_CFG_RDATA : I_GOLD_DATA);
    wire [5:0]  ram_raddr = (state == fes_pkg::ST_FETCH) ? flip_word : cnt;

    // *****************************************************************
    // frame store and syndrome decode
    // *****************************************************************
    fes_frame_ram u_ram (
        .i_clk   (I_SYS_CLK),
        .i_we    (ram_we),
        .i_waddr (ram_waddr),
        .i_wdata (ram_wdata),
        .i_raddr (ram_raddr),
        .o_rdata (ram_rdata)
    );

    fes_syndrome_decode u_dec (
        .i_syndrome  (syn),
        .o_single    (dec_single),
        .o_parity    (dec_parity),
        .o_bit_index (dec_index)
    );

    // *****************************************************************
    // next state
    // *****************************************************************
    always_comb begin
        next_state = state;
        case (state)
            fes_pkg::ST_IDLE: begin
                if (I_START) begin
                    next_state = fes_pkg::ST_READ;
                end
            end
            fes_pkg::ST_READ: begin
                // a full frame is in the store once the last word lands
                if (rd_take && (cnt == fes_pkg::LAST_WORD)) begin
                    next_state = fes_pkg::ST_CHECK;
                end
            end
            fes_pkg::ST_CHECK: begin
                // readback is halted here until the verdict arrives
                if (I_FRAME_CHECK_VALID) begin
                    if (!I_FRAME_ERROR_FLAG) begin
                        next_state = fes_pkg::ST_NEXT;
                    end else if (I_SYNDROME[fes_pkg::SYN_SEC]) begin
                        next_state = fes_pkg::ST_FETCH;
                    end else begin
                        next_state = fes_pkg::ST_GOLD;
                    end
                end
            end
            fes_pkg::ST_FETCH: begin
                next_state = fes_pkg::ST_FLIP;
            end
            fes_pkg::ST_FLIP: begin
                next_state = fes_pkg::ST_WRITE;
            end
            fes_pkg::ST_GOLD: begin
                if (gold_take && (cnt == fes_pkg::LAST_WORD)) begin
                    next_state = fes_pkg::ST_WRITE;
                end
            end
            fes_pkg::ST_WRITE: begin
                // wait until the last word has left the pipeline
                if ((cnt == fes_pkg::FRAME_WORDS) && !wr_pipe) begin
                    next_state = fes_pkg::ST_NEXT;
                end
            end
            fes_pkg::ST_NEXT: begin
                next_state = stop_req ? fes_pkg::ST_IDLE : fes_pkg::ST_READ;
            end
            default: begin
                next_state = fes_pkg::ST_IDLE;
            end
        endcase
    end

    // word counter restarts on every state change
    always_comb begin
        if (next_state != state) begin
            next_cnt = 6'h00;
        end else if (cnt_step) begin
            next_cnt = cnt + 6'h01;
        end else begin
            next_cnt = cnt;
        end
    end

    // *****************************************************************
    // state registers
    // *****************************************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            state   <= fes_pkg::ST_IDLE;
            cnt     <= 6'h00;
            wr_pipe <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            wr_pipe <= wr_issue;
        end
    end

    // stop is honoured only between frames; set wins over clear
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            stop_req <= 1'b0;
        end else if (I_STOP) begin
            stop_req <= 1'b1;
        end else if (state == fes_pkg::ST_IDLE) begin
            stop_req <= 1'b0;
        end
    end

    // syndrome is saved only in the strobe cycle
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            syn <= 12'h000;
        end else if (take_syn) begin
            syn <= I_SYNDROME;
        end
    end

    // *****************************************************************
    // frame address
    // *****************************************************************
    // held through repair so the write goes back to the same frame
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_FRAME_ADDR <= 24'h000000;
        end else if ((state == fes_pkg::ST_IDLE) && I_START) begin
            O_FRAME_ADDR <= 24'h000000;
        end else if (state == fes_pkg::ST_NEXT) begin
            O_FRAME_ADDR <= last_addr ? 24'h000000
                                      : (O_FRAME_ADDR + 24'h000001);
        end
    end

    // *****************************************************************
    // access port drive
    // *****************************************************************
    // select follows the next state so no stray read is issued
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_CFG_CE_N  <= 1'b1;
            O_CFG_RDWR  <= 1'b1;
            O_CFG_WDATA <= 32'h0000_0000;
        end else begin
            O_CFG_CE_N  <= ~((next_state == fes_pkg::ST_READ) | wr_pipe);
            O_CFG_RDWR  <= (next_state == fes_pkg::ST_READ);
            O_CFG_WDATA <= wr_pipe ? ram_rdata : 32'h0000_0000;
        end
    end

    // *****************************************************************
    // status outputs
    // *****************************************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_GOLD_REQ        <= 1'b0;
            O_CAPTURE_INHIBIT <= 1'b0;
            O_SYNDROME        <= 12'h000;
            O_REPAIR_DONE     <= 1'b0;
            O_DOUBLE_ERR      <= 1'b0;
        end else begin
            O_GOLD_REQ        <= (next_state == fes_pkg::ST_GOLD);
            // capture would corrupt the frames being checked
            O_CAPTURE_INHIBIT <= (next_state != fes_pkg::ST_IDLE);
            O_SYNDROME        <= take_syn ? I_SYNDROME : syn;
            O_REPAIR_DONE     <= (state == fes_pkg::ST_WRITE)
                               & (next_state == fes_pkg::ST_NEXT);
            O_DOUBLE_ERR      <= take_syn & I_FRAME_ERROR_FLAG
                               & ~I_SYNDROME[fes_pkg::SYN_SEC];
        end
    end

    // *****************************************************************
    // assertions
    // *****************************************************************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);

    // decoded single error seen at the strobe
    sequence s_single_verdict;
        take_syn && I_FRAME_ERROR_FLAG && I_SYNDROME[11];
    endsequence
    sequence s_flip_steps;
        (state == fes_pkg::ST_FETCH) ##1 (state == fes_pkg::ST_FLIP && ram_we)
            ##1 (state == fes_pkg::ST_WRITE);
    endsequence

    wire dec_data = (state == fes_pkg::ST_FETCH) & dec_single & ~dec_parity;
    wire dec_par  = (state == fes_pkg::ST_FETCH) & dec_parity;

    AST_SAMPLE_AT_STROBE: assert property (
        !$stable(syn) |-> $past(take_syn))
        else $error("saved syndrome changed outside the strobe");

    AST_DATA_RANGE: assert property (
        dec_data |-> (dec_index < 11'h520))
        else $error("data bit index beyond the frame");

    AST_DATA_OFFSET: assert property (
        dec_data |-> (dec_index == ((syn[10:0] < 11'h400) ? (syn[10:0] - 11'h2C0)
                                                         : (syn[10:0] - 11'h2E0))))
        else $error("data bit index offset wrong");

    AST_SHORT_FORM: assert property (
        dec_data |-> (dec_index == {6'(syn[10:5] - 6'h16 - {5'h00, syn[10]}), syn[4:0]}))
        else $error("row form disagrees with offset form");

    AST_PARITY_LOC: assert property (
        dec_par |-> (dec_index >= 11'h280) && (dec_index <= 11'h28B))
        else $error("parity location outside 640 to 651");

    AST_PARITY_ONEHOT: assert property (
        dec_par && (syn[10:0] != 11'h000)
            |-> ((11'h001 << (dec_index - 11'h280)) == syn[10:0]))
        else $error("parity bit k not mapped to 640 plus k");

    AST_FULL_FRAME: assert property (
        (state == fes_pkg::ST_READ) && (next_state == fes_pkg::ST_CHECK)
            |=> $past(cnt) == 6'h28)
        else $error("frame left read before 41 words");

    AST_READ_PORT: assert property (
        (state == fes_pkg::ST_READ) && !O_CFG_CE_N |-> O_CFG_RDWR)
        else $error("read state without read select");

    AST_SINGLE_FLIP: assert property (
        s_single_verdict |=> s_flip_steps)
        else $error("single error did not invert one bit");

    AST_DOUBLE_RELOAD: assert property (
        take_syn && I_FRAME_ERROR_FLAG && !I_SYNDROME[11]
            |=> (state == fes_pkg::ST_GOLD) ##1 O_GOLD_REQ)
        else $error("double error did not request original frame");

    AST_SAME_ADDR: assert property (
        (state == fes_pkg::ST_WRITE) |-> $stable(O_FRAME_ADDR))
        else $error("frame address moved during write back");

    AST_RESUME_NEXT: assert property (
        (state == fes_pkg::ST_NEXT) && !last_addr
            |=> O_FRAME_ADDR == $past(O_FRAME_ADDR) + 24'h000001)
        else $error("readback did not resume at next frame");

    AST_CAPTURE_OFF: assert property (
        (state != fes_pkg::ST_IDLE) && (next_state != fes_pkg::ST_IDLE)
            |=> O_CAPTURE_INHIBIT)
        else $error("capture allowed while checking");

endmodule : fes_repair_ctrl

// file: testbench/fes_dev_model.sv
/* device model: access port over a one-frame store, frame checker
   verdict and original-frame source.
   assumes the bench sets the verdict syndrome before each scan. */
`timescale 1ns/1ps
module fes_dev_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // access port
    input  wire logic        i_ce_n,
    input  wire logic        i_rdwr,
    input  wire logic [31:0] i_wdata,
    output logic      [31:0] o_rdata,
    output logic             o_busy,
    // checker verdict
    input  wire logic        i_slow,
    input  wire logic [11:0] i_syn,
    output logic             o_valid,
    output logic             o_flag,
    output logic      [11:0] o_syn,
    // original frame source
    input  wire logic        i_gold_req,
    output logic             o_gold_valid,
    output logic      [31:0] o_gold_data
);
    // ***************************************************************
    // store and port
    // ***************************************************************
    logic [31:0] mem [0:40];   // frame store, bench may preload
    logic [5:0]  rc, wc, gc;   // read, write, original word counts
    logic        stall;        // every other read cycle when slow
    wire         rd = !i_ce_n && i_rdwr;
    wire         gnext = i_gold_req && gc < 6'h29;
    assign o_busy  = rd & stall;   // busy stays low on writes
    // a stalled or released bus shows the inverse, never a stale match
    assign o_rdata = (rd && !stall) ? mem[rc] : ~mem[rc];
    // verdict is only trustworthy in the strobe cycle
    assign o_flag  = o_valid ? |i_syn : ~|i_syn;
    assign o_syn   = o_valid ? i_syn : ~i_syn;
    // one strobe per frame, all on the port clock
    always @(posedge i_clk) begin
        o_valid      <= rd && !stall && rc == 6'h28 && !i_rst;
        stall        <= i_slow & ~stall;
        o_gold_valid <= gnext;
        o_gold_data  <= gnext ? 32'hC0DE0000 + {26'h0, gc} : ~o_gold_data;
        gc           <= i_gold_req ? gc + {5'h0, gnext} : 6'h00;
        if (i_rst) begin
            rc <= 6'h00;
            wc <= 6'h00;
        end else begin
            if (rd && !stall)
                rc <= (rc == 6'h28) ? 6'h00 : rc + 6'h01;
            if (!i_ce_n && !i_rdwr) begin
                mem[wc] <= i_wdata;
                wc      <= (wc == 6'h28) ? 6'h00 : wc + 6'h01;
            end
        end
    end
endmodule : fes_dev_model

// file: testbench/tb.sv
/* self-checking bench for the frame repair controller.
   assumes the device model stands on the far side of the access, checker and original-frame ports. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
`define WAIT(c) for (int k = 0; k < 2000 && !(c); k++) step();
module tb;
    logic        clk = 0, rst = 1, start = 0, stop = 0, slow = 0;
    logic [11:0] syn_set = 12'h000;
    logic        ce_n, rdwr, busy, chk_v, chk_f, greq, gval, inhib, done, dbl;
    logic [11:0] chk_s, syn_o;
    logic [31:0] wdata, rdata, gdata;
    logic [23:0] faddr;
    int          err_total = 0, n_checks = 0, cyc = 0;
    logic [11:0] cases [6] = '{12'hAC0, 12'hAE5, 12'hC64, 12'hFFF, 12'h808, 12'h800};
    always #10 clk = ~clk;
    fes_repair_ctrl i_dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_START(start), .I_STOP(stop),
        .I_LAST_FRAME_ADDR(24'h000001), .I_FRAME_CHECK_VALID(chk_v),
        .I_FRAME_ERROR_FLAG(chk_f), .I_SYNDROME(chk_s), .O_CFG_CE_N(ce_n),
        .O_CFG_RDWR(rdwr), .O_CFG_WDATA(wdata), .I_CFG_RDATA(rdata), .I_CFG_BUSY(busy),
        .O_FRAME_ADDR(faddr), .O_GOLD_REQ(greq), .I_GOLD_VALID(gval), .I_GOLD_DATA(gdata),
        .O_CAPTURE_INHIBIT(inhib), .O_SYNDROME(syn_o), .O_REPAIR_DONE(done),
        .O_DOUBLE_ERR(dbl));
    fes_dev_model i_dev (.i_clk(clk), .i_rst(rst), .i_ce_n(ce_n), .i_rdwr(rdwr),
        .i_wdata(wdata), .o_rdata(rdata), .o_busy(busy), .i_slow(slow), .i_syn(syn_set),
        .o_valid(chk_v), .o_flag(chk_f), .o_syn(chk_s), .i_gold_req(greq),
        .o_gold_valid(gval), .o_gold_data(gdata));
    // ***************************************************************
    // helpers
    // ***************************************************************
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // frame index of the bit a single-error syndrome points at
    function automatic int loc(input logic [11:0] s);
        if (s[10:0] == 11'h000) return 651;
        if ((s[10:0] & (s[10:0] - 11'h001)) == 11'h000) return 640 + $clog2(s[10:0]);
        return (s[10:0] < 11'h400) ? s[10:0] - 704 : s[10:0] - 736;
    endfunction : loc
    // preload the frame, start a scan, hold the verdict past its strobe
    task automatic scan(input logic [11:0] s);
        for (int w = 0; w < 41; w++) i_dev.mem[w] = 32'hA5000000 + w;
        syn_set = s;
        start = 1;
        step();
        start = 0;
        `CHK(ce_n, 1'b0)
        `CHK(rdwr, 1'b1)
        `CHK(inhib, 1'b1)
        `WAIT(chk_v)
        step();
        syn_set = 12'h000;
    endtask : scan
    // stop request, honoured at a frame boundary
    task automatic halt();
        stop = 1;
        step();
        stop = 0;
        `WAIT(!inhib)
        `CHK(inhib, 1'b0)
    endtask : halt
    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic t_clean();
        scan(12'h000);
        `WAIT(faddr == 24'h000001)
        `CHK(faddr, 24'h000001)
        `CHK(i_dev.mem[40], 32'hA5000028)
        halt();
        `CHK(faddr, 24'h000000)
        $display("clean frame test done");
    endtask : t_clean
    // single flip: exactly the located bit is inverted, same address
    task automatic t_single(input logic [11:0] s);
        int          i;
        logic [31:0] m;
        i = loc(s);
        scan(s);
        `WAIT(done)
        `CHK(done, 1'b1)
        `CHK(syn_o, s)
        `CHK(faddr, 24'h000000)
        for (int w = 0; w < 41; w++) begin
            m = (w == i / 32) ? 32'h1 << (i % 32) : 32'h0;
            `CHK(i_dev.mem[w], (32'hA5000000 + w) ^ m)
        end
        step();
        `CHK(faddr, 24'h000001)
        halt();
        $display("single error test %h done", s);
    endtask : t_single
    // double flip: original frame reloaded and written back
    task automatic t_double();
        scan(12'h055);
        `WAIT(dbl)
        `CHK(dbl, 1'b1)
        `CHK(syn_o, 12'h055)
        `CHK(greq, 1'b1)
        `WAIT(done)
        `CHK(done, 1'b1)
        `CHK(greq, 1'b0)
        for (int w = 0; w < 41; w++)
            `CHK(i_dev.mem[w], 32'hC0DE0000 + w)
        halt();
        $display("double error test done");
    endtask : t_double
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        step(16);
        rst = 0;
        `CHK(ce_n, 1'b1)
        `CHK(syn_o, 12'h000)
        t_clean();
        slow = 1;   // stalled reads from here on
        foreach (cases[j]) t_single(cases[j]);
        t_double();
        finish_test();
    end
endmodule : tb
